// >>> quad_rb_link_assertions.sv
// Concurrent checks on the two-wire readback link
module quad_rb_link_assertions (
	input wire logic clk_link,
	input wire logic rst,
	input wire logic mscl_o,
	input wire logic mscl_oe,
	input wire logic msda_o,
	input wire logic msda_oe,
	input wire logic dsda_o,
	input wire logic dsda_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge clk_link);
	endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////
	// Wire level
	tied_low_a: assert property (!mscl_o && !msda_o && !dsda_o)
		else $error("open-drain output value not low");
	scl_wire_a: assert property (scl == !mscl_oe)
		else $error("clock wire level disagrees with master enable");
	sda_wire_a: assert property (sda == !(msda_oe || dsda_oe))
		else $error("data wire level disagrees with enables");

	////////////////////////////////////////////////////////////////////////////
	// Framing
	dev_stable_a: assert property (scl && $past(scl) |-> $stable(dsda_oe))
		else $error("device changed data while clock high");
	start_free_a: assert property ($fell(sda) && scl && $past(scl) |-> !dsda_oe)
		else $error("device holds data line at a start");
	dev_release_a: assert property ($rose(dsda_oe) |-> ##[1:300] !dsda_oe)
		else $error("device never released data line");
	scl_low_a: assert property ($fell(scl) |-> !scl [*4])
		else $error("clock low phase too short");
	stop_idle_a: assert property ($rose(sda) && scl && $past(scl) |-> (scl && sda) [*4])
		else $error("bus not idle after stop");

	////////////////////////////////////////////////////////////////////////////
	// Coverage
	start_seen_c: cover property ($fell(sda) && scl);
	stop_seen_c: cover property ($rose(sda) && scl);
	dev_ack_c: cover property (dsda_oe && scl);
endmodule

// >>> quad_rb_map.svh
// Constants of the readback link: field positions, codes, counts and register map
`ifndef QUAD_RB_MAP_SVH
`define QUAD_RB_MAP_SVH

// Address byte
`define AB_PREFIX 7:3
`define AB_PINS 2:1
`define AB_RW 0
`define ADDR_PREFIX 5'h13
`define RW_WRITE 1'b0
`define RW_READ 1'b1

// Control byte
`define CB_EXT 7:6
`define CB_LOAD 5:4
`define CB_SEL 2:1
`define CB_PD 0
`define CB_SPARE 1'b0

// Channel word
`define CW_PDMODE 13:12
`define CW_HI 11:4
`define CW_LO 3:0
`define PD_FILL 6'h3F
`define LO_FILL 4'h0

// Byte sequencing
`define BYTE_BITS 4'h8
`define LAST_IDX_PD 2'h2
`define LAST_IDX_DATA 2'h1
`define SLOT_PD 2'h0
`define SLOT_HI 2'h1

// Controller register map
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_DATA 4'h8
`define CR_GO 0
`define CR_PINS 2:1
`define CR_EXT 4:3
`define CR_LOAD 6:5
`define CR_SEL 8:7
`define CR_PD 9
`define CR_W 10
`define ST_BUSY 0
`define ST_DONE 1
`define ST_NACK 2
`define DR_BYTES 23:0
`define DR_COUNT 25:24

// Serial clock timing
`define SCL_PERIOD_NS 10000
`define CLK_SYS_MHZ 200
`define QUARTERS 4

`endif

// >>> quad_rb_master.sv
// Controller end of the readback link: master receiver with a register port
`include "quad_rb_map.svh"

module quad_rb_master
	import quad_rb_pkg::*;
#(
	parameter int QUARTER_CYC = `SCL_PERIOD_NS * `CLK_SYS_MHZ / 1000 / `QUARTERS
) (
	input wire logic clk_sys,
	input wire logic rst,
	two_wire_if.master link,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [31:0] reg_rdata_q
);

	////////////////////////////////////////////////////////////////////////////
	// State

	logic sda_meta_q;
	logic sda_s_q;
	mst_state_e state_q;
	mst_state_e state_d;
	logic [15:0] div_q;
	logic [1:0] ph_q;
	logic [1:0] ph_d;
	logic [3:0] bit_q;
	logic [3:0] bit_d;
	byte_t sh_q;
	byte_t sh_d;
	logic [1:0] stage_q;
	logic [1:0] stage_d;
	logic [1:0] rd_idx_q;
	logic [1:0] rd_idx_d;
	logic [`CR_W-1:0] cfg_q;
	logic [`CR_W-1:0] cfg_d;
	logic [23:0] data_q;
	logic [23:0] data_d;
	logic [1:0] count_q;
	logic [1:0] count_d;
	logic busy_q;
	logic done_q;
	logic done_d;
	logic nack_q;
	logic nack_d;
	logic scl_oe_q;
	logic scl_oe_d;
	logic sda_oe_q;
	logic sda_oe_d;

	////////////////////////////////////////////////////////////////////////////
	// Decoding

	wire tick = div_q == 16'(QUARTER_CYC - 1);
	wire wr_ctrl = reg_we && (reg_addr == `REG_CTRL);
	wire wr_status = reg_we && (reg_addr == `REG_STATUS);
	wire go = wr_ctrl && reg_wdata[`CR_GO] && !busy_q;
	wire [7:0] addr_w = {`ADDR_PREFIX, cfg_q[`CR_PINS], `RW_WRITE};
	wire [7:0] addr_r = {`ADDR_PREFIX, cfg_q[`CR_PINS], `RW_READ};
	wire [7:0] ctrl_b = {cfg_q[`CR_EXT], cfg_q[`CR_LOAD], `CB_SPARE, cfg_q[`CR_SEL], cfg_q[`CR_PD]};
	wire [1:0] last_idx = cfg_q[`CR_PD] ? `LAST_IDX_PD : `LAST_IDX_DATA;
	wire rd_last = rd_idx_q == last_idx;
	wire [7:0] sh_in = {sh_q[6:0], sda_s_q};
	wire bit_end = bit_q == (`BYTE_BITS - 4'h1);
	wire [31:0] status_w = {29'h0, nack_q, done_q, busy_q};
	wire [31:0] data_w = {6'h0, count_q, data_q};
	wire [31:0] cfg_w = {22'h0, cfg_q};
	wire [31:0] rd_mux = (reg_addr == `REG_CTRL) ? cfg_w :
		(reg_addr == `REG_STATUS) ? status_w :
		(reg_addr == `REG_DATA) ? data_w : 32'h0;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_comb begin
		state_d = state_q;
		ph_d = ph_q;
		bit_d = bit_q;
		sh_d = sh_q;
		stage_d = stage_q;
		rd_idx_d = rd_idx_q;
		cfg_d = cfg_q;
		data_d = data_q;
		count_d = count_q;
		nack_d = nack_q;
		scl_oe_d = scl_oe_q;
		sda_oe_d = sda_oe_q;
		done_d = done_q && !(wr_status && reg_wdata[`ST_DONE]);
		if (wr_ctrl && !busy_q) begin
			cfg_d = reg_wdata[`CR_W-1:0];
		end
		if (go) begin
			state_d = M_START;
			ph_d = 2'h0;
			stage_d = 2'h0;
			data_d = 24'h0;
			count_d = 2'h0;
			nack_d = 1'b0;
			done_d = 1'b0;
		end else if (tick && state_q != M_IDLE) begin
			ph_d = ph_q + 2'h1;
			unique case (ph_q)
				2'h0: begin
					sda_oe_d = (state_q == M_STOP) ||
						(state_q == M_WBIT && !sh_q[7]) ||
						(state_q == M_MACK && !rd_last);
				end
				2'h1: begin
					scl_oe_d = 1'b0;
				end
				2'h2: begin
					if (state_q == M_START) begin
						sda_oe_d = 1'b1;
					end else if (state_q == M_STOP) begin
						sda_oe_d = 1'b0;
					end
				end
				2'h3: begin
					scl_oe_d = state_q != M_STOP;
					unique case (state_q)
						M_START: begin
							state_d = M_WBIT;
							bit_d = 4'h0;
							sh_d = (stage_q == 2'h2) ? addr_r : addr_w;
						end
						M_WBIT: begin
							sh_d = {sh_q[6:0], 1'b0};
							bit_d = bit_q + 4'h1;
							if (bit_end) begin
								state_d = M_WACK;
							end
						end
						M_WACK: begin
							bit_d = 4'h0;
							if (sda_s_q) begin
								nack_d = 1'b1;
								state_d = M_STOP;
							end else if (stage_q == 2'h0) begin
								sh_d = ctrl_b;
								stage_d = 2'h1;
								state_d = M_WBIT;
							end else if (stage_q == 2'h1) begin
								stage_d = 2'h2;
								state_d = M_START;
							end else begin
								rd_idx_d = 2'h0;
								state_d = M_RBIT;
							end
						end
						M_RBIT: begin
							sh_d = sh_in;
							bit_d = bit_q + 4'h1;
							if (bit_end) begin
								data_d = {data_q[15:0], sh_in};
								count_d = rd_idx_q + 2'h1;
								state_d = M_MACK;
							end
						end
						M_MACK: begin
							bit_d = 4'h0;
							rd_idx_d = rd_idx_q + 2'h1;
							state_d = rd_last ? M_STOP : M_RBIT;
						end
						M_STOP: begin
							done_d = 1'b1;
							state_d = M_IDLE;
						end
						default: begin
							state_d = M_IDLE;
						end
					endcase
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sda_meta_q <= 1'b1;
			sda_s_q <= 1'b1;
			div_q <= 16'h0000;
			state_q <= M_IDLE;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			stage_q <= 2'h0;
			rd_idx_q <= 2'h0;
			cfg_q <= '0;
			data_q <= 24'h0;
			count_q <= 2'h0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			nack_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			reg_rdata_q <= 32'h0;
		end else begin
			sda_meta_q <= link.sda;
			sda_s_q <= sda_meta_q;
			div_q <= (tick || go) ? 16'h0000 : div_q + 16'h0001;
			state_q <= state_d;
			ph_q <= ph_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			stage_q <= stage_d;
			rd_idx_q <= rd_idx_d;
			cfg_q <= cfg_d;
			data_q <= data_d;
			count_q <= count_d;
			busy_q <= state_d != M_IDLE;
			done_q <= done_d;
			nack_q <= nack_d;
			scl_oe_q <= scl_oe_d;
			sda_oe_q <= sda_oe_d;
			reg_rdata_q <= reg_re ? rd_mux : 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Open-drain drive: low only

	assign link.mscl_o = 1'b0;
	assign link.mscl_oe = scl_oe_q;
	assign link.msda_o = 1'b0;
	assign link.msda_oe = sda_oe_q;

endmodule

// >>> quad_rb_pkg.sv
// State types shared by both ends of the readback link
package quad_rb_pkg;

	typedef logic [7:0] byte_t;

	typedef enum logic [6:0] {
		D_IDLE = 7'b0000001,
		D_ADDR = 7'b0000010,
		D_AACK = 7'b0000100,
		D_CTRL = 7'b0001000,
		D_CACK = 7'b0010000,
		D_TX = 7'b0100000,
		D_MACK = 7'b1000000
	} dev_state_e;

	typedef enum logic [6:0] {
		M_IDLE = 7'b0000001,
		M_START = 7'b0000010,
		M_WBIT = 7'b0000100,
		M_WACK = 7'b0001000,
		M_RBIT = 7'b0010000,
		M_MACK = 7'b0100000,
		M_STOP = 7'b1000000
	} mst_state_e;

endpackage

// >>> quad_rb_slave.sv
// Converter end of the readback link: slave transmitter on the link clock
//
// Added by the designer: the busy_q and pdmode_q outputs.
`include "quad_rb_map.svh"

////////////////////////////////////////////////////////////////////////////////
module quad_rb_slave
	import quad_rb_pkg::*;
(
	input wire logic clk_link,
	input wire logic rst,
	two_wire_if.device link,
	input wire logic addr_pin_hi,
	input wire logic addr_pin_lo,
	input wire logic [13:0] chan_word [4],
	output logic [1:0] sel_channel_q,
	output logic powerdown_flag_q,
	output logic [1:0] load_ctrl_q,
	output logic [1:0] ext_addr_q,
	output logic [1:0] pdmode_q,
	output logic busy_q
);

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic scl_meta_q;
	logic scl_s_q;
	logic scl_p_q;
	logic sda_meta_q;
	logic sda_s_q;
	logic sda_p_q;
	logic [1:0] pins_meta_q;
	logic [1:0] pins_q;
	logic [13:0] cw_meta_q [4];
	logic [13:0] cw_q [4];

	always_ff @(posedge clk_link or posedge rst) begin
		if (rst) begin
			scl_meta_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_meta_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
			pins_meta_q <= 2'h0;
			pins_q <= 2'h0;
		end else begin
			scl_meta_q <= link.scl;
			scl_s_q <= scl_meta_q;
			scl_p_q <= scl_s_q;
			sda_meta_q <= link.sda;
			sda_s_q <= sda_meta_q;
			sda_p_q <= sda_s_q;
			pins_meta_q <= {addr_pin_hi, addr_pin_lo};
			pins_q <= pins_meta_q;
		end
	end

	// Channel words cleared at reset, one synchroniser per channel
	for (genvar ch = 0; ch < 4; ch++) begin : g_chan
		always_ff @(posedge clk_link or posedge rst) begin
			if (rst) begin
				cw_meta_q[ch] <= 14'h0000;
				cw_q[ch] <= 14'h0000;
			end else begin
				cw_meta_q[ch] <= chan_word[ch];
				cw_q[ch] <= cw_meta_q[ch];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Line events

	wire scl_rise = scl_s_q && !scl_p_q;
	wire scl_fall = !scl_s_q && scl_p_q;
	wire start_seen = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
	wire stop_seen = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

	////////////////////////////////////////////////////////////////////////////
	// State

	dev_state_e state_q;
	dev_state_e state_d;
	logic [3:0] bit_cnt_q;
	logic [3:0] bit_cnt_d;
	byte_t shift_q;
	byte_t shift_d;
	byte_t tx_q;
	byte_t tx_d;
	logic sda_oe_q;
	logic sda_oe_d;
	logic rw_q;
	logic rw_d;
	logic [1:0] byte_idx_q;
	logic [1:0] byte_idx_d;
	logic more_q;
	logic more_d;
	logic [1:0] sel_d;
	logic pd_d;
	logic [1:0] load_d;
	logic [1:0] ext_d;

	////////////////////////////////////////////////////////////////////////////
	// Decoding and byte selection

	wire byte_full = bit_cnt_q == `BYTE_BITS;
	wire addr_hit = (shift_q[`AB_PREFIX] == `ADDR_PREFIX) && (shift_q[`AB_PINS] == pins_q);
	wire [13:0] cur_word = cw_q[sel_channel_q];
	wire [1:0] last_idx = powerdown_flag_q ? `LAST_IDX_PD : `LAST_IDX_DATA;
	wire [1:0] slot = powerdown_flag_q ? byte_idx_q : byte_idx_q + 2'h1;
	wire [7:0] pd_byte = {cur_word[`CW_PDMODE], `PD_FILL};
	wire [7:0] hi_byte = cur_word[`CW_HI];
	wire [7:0] lo_byte = {cur_word[`CW_LO], `LO_FILL};
	wire [7:0] cur_byte = (slot == `SLOT_PD) ? pd_byte : (slot == `SLOT_HI) ? hi_byte : lo_byte;
	wire master_ack = !sda_s_q;

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		state_d = state_q;
		bit_cnt_d = bit_cnt_q;
		shift_d = shift_q;
		tx_d = tx_q;
		sda_oe_d = sda_oe_q;
		rw_d = rw_q;
		byte_idx_d = byte_idx_q;
		more_d = more_q;
		sel_d = sel_channel_q;
		pd_d = powerdown_flag_q;
		load_d = load_ctrl_q;
		ext_d = ext_addr_q;
		if (stop_seen) begin
			state_d = D_IDLE;
			sda_oe_d = 1'b0;
		end else if (start_seen) begin
			state_d = D_ADDR;
			bit_cnt_d = 4'h0;
			sda_oe_d = 1'b0;
		end else begin
			unique case (state_q)
				D_IDLE: begin
					sda_oe_d = 1'b0;
				end
				D_ADDR, D_CTRL: begin
					if (scl_rise && !byte_full) begin
						shift_d = {shift_q[6:0], sda_s_q};
						bit_cnt_d = bit_cnt_q + 4'h1;
					end else if (scl_fall && byte_full) begin
						bit_cnt_d = 4'h0;
						if (state_q == D_CTRL) begin
							sel_d = shift_q[`CB_SEL];
							pd_d = shift_q[`CB_PD];
							load_d = shift_q[`CB_LOAD];
							ext_d = shift_q[`CB_EXT];
							sda_oe_d = 1'b1;
							state_d = D_CACK;
						end else if (addr_hit) begin
							rw_d = shift_q[`AB_RW];
							byte_idx_d = 2'h0;
							sda_oe_d = 1'b1;
							state_d = D_AACK;
						end else begin
							state_d = D_IDLE;
						end
					end
				end
				D_AACK: begin
					if (scl_fall) begin
						if (rw_q == `RW_READ) begin
							tx_d = {cur_byte[6:0], 1'b0};
							sda_oe_d = !cur_byte[7];
							state_d = D_TX;
						end else begin
							sda_oe_d = 1'b0;
							state_d = D_CTRL;
						end
					end
				end
				D_CACK: begin
					if (scl_fall) begin
						sda_oe_d = 1'b0;
						state_d = D_IDLE;
					end
				end
				D_TX: begin
					if (scl_rise) begin
						bit_cnt_d = bit_cnt_q + 4'h1;
					end else if (scl_fall) begin
						if (byte_full) begin
							sda_oe_d = 1'b0;
							bit_cnt_d = 4'h0;
							more_d = 1'b0;
							state_d = D_MACK;
						end else begin
							sda_oe_d = !tx_q[7];
							tx_d = {tx_q[6:0], 1'b0};
						end
					end
				end
				D_MACK: begin
					if (scl_rise) begin
						more_d = master_ack && (byte_idx_q != last_idx);
						if (master_ack && (byte_idx_q != last_idx)) begin
							byte_idx_d = byte_idx_q + 2'h1;
						end
					end else if (scl_fall) begin
						if (more_q) begin
							tx_d = {cur_byte[6:0], 1'b0};
							sda_oe_d = !cur_byte[7];
							state_d = D_TX;
						end else begin
							sda_oe_d = 1'b0;
							state_d = D_IDLE;
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk_link or posedge rst) begin
		if (rst) begin
			state_q <= D_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			sda_oe_q <= 1'b0;
			rw_q <= 1'b0;
			byte_idx_q <= 2'h0;
			more_q <= 1'b0;
		end else begin
			state_q <= state_d;
			bit_cnt_q <= bit_cnt_d;
			shift_q <= shift_d;
			tx_q <= tx_d;
			sda_oe_q <= sda_oe_d;
			rw_q <= rw_d;
			byte_idx_q <= byte_idx_d;
			more_q <= more_d;
		end
	end

	always_ff @(posedge clk_link or posedge rst) begin
		if (rst) begin
			sel_channel_q <= 2'h0;
			powerdown_flag_q <= 1'b0;
			load_ctrl_q <= 2'h0;
			ext_addr_q <= 2'h0;
			pdmode_q <= 2'h0;
			busy_q <= 1'b0;
		end else begin
			sel_channel_q <= sel_d;
			powerdown_flag_q <= pd_d;
			load_ctrl_q <= load_d;
			ext_addr_q <= ext_d;
			pdmode_q <= cw_q[sel_d][`CW_PDMODE];
			busy_q <= state_d != D_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Open-drain drive: low only

	assign link.dsda_o = 1'b0;
	assign link.dsda_oe = sda_oe_q;

endmodule

// >>> test_quad_dac_i2c_readback.sv
// Self-checking bench joining both ends of the readback link
module test_quad_dac_i2c_readback;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk_sys, clk_link, rst, pin_hi, pin_lo, reg_we, reg_re, pd;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata_q, rd;
	logic [13:0] cw [4];
	logic [13:0] w;
	logic [7:0] pdb;
	logic [1:0] ch, sel_channel_q, load_ctrl_q, ext_addr_q, pdmode_q;
	logic powerdown_flag_q, busy_q;
	int num_errors, tests_run;

	two_wire_if link_if ();

	quad_rb_master #(.QUARTER_CYC(40)) u_quad_rb_master (.clk_sys(clk_sys), .rst(rst),
		.link(link_if), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re), .reg_rdata_q(reg_rdata_q));

	quad_rb_slave u_quad_rb_slave (.clk_link(clk_link), .rst(rst), .link(link_if),
		.addr_pin_hi(pin_hi), .addr_pin_lo(pin_lo), .chan_word(cw),
		.sel_channel_q(sel_channel_q), .powerdown_flag_q(powerdown_flag_q),
		.load_ctrl_q(load_ctrl_q), .ext_addr_q(ext_addr_q), .pdmode_q(pdmode_q),
		.busy_q(busy_q));

	quad_rb_link_assertions u_quad_rb_link_assertions (.clk_link(clk_link), .rst(rst),
		.mscl_o(link_if.mscl_o), .mscl_oe(link_if.mscl_oe), .msda_o(link_if.msda_o),
		.msda_oe(link_if.msda_oe), .dsda_o(link_if.dsda_o), .dsda_oe(link_if.dsda_oe),
		.scl(link_if.scl), .sda(link_if.sda));

	////////////////////////////////////////////////////////////////////////////
	// Clocks and watchdog
	initial begin
		clk_sys = 1'h0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	initial begin
		clk_link = 1'h0;
		#7.3;
		forever #16 clk_link = ~clk_link;
	end

	initial begin
		#450000;
		num_errors++;
		results;
	end

	////////////////////////////////////////////////////////////////////////////
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		if (num_errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'h1;
		@(posedge clk_sys);
		reg_we <= 1'h0;
	endtask

	task automatic rdreg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_re <= 1'h1;
		@(posedge clk_sys);
		reg_re <= 1'h0;
		@(negedge clk_sys);
		d = reg_rdata_q;
	endtask

	task automatic run(input logic [1:0] pins, input logic [1:0] c, input logic f);
		logic [31:0] s;
		wr(4'h0, {22'h0, f, c, ~c, c, pins, 1'h1});
		s = 32'h1;
		for (int n = 0; n < 6000 && s[0] !== 1'h0; n++) begin
			rdreg(4'h4, s);
		end
		if (s[0] !== 1'h0) begin
			num_errors++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Tests
	initial begin
		rst = 1'h1;
		reg_we = 1'h0;
		reg_re = 1'h0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		pin_hi = 1'h1;
		pin_lo = 1'h0;
		num_errors = 0;
		tests_run = 0;
		cw[0] = 14'h0123;
		cw[1] = 14'h1FED;
		cw[2] = 14'h2A50;
		cw[3] = 14'h3C0F;
		repeat (5) @(posedge clk_link);
		@(posedge clk_sys);
		rst <= 1'h0;
		repeat (3) @(posedge clk_link);
		rdreg(4'h4, rd);
		check(rd, 32'h0);
		rdreg(4'h8, rd);
		check(rd, 32'h0);
		for (int i = 0; i < 8; i++) begin
			ch = i[1:0];
			pd = i[2];
			w = cw[ch];
			pdb = pd ? {w[13:12], 6'h3F} : 8'h00;
			run(2'h2, ch, pd);
			rdreg(4'h4, rd);
			check(rd, 32'h2);
			rdreg(4'h8, rd);
			check(rd, {6'h00, pd ? 2'h3 : 2'h2, pdb, w[11:4], w[3:0], 4'h0});
			check({30'h0, sel_channel_q}, {30'h0, ch});
			check({31'h0, powerdown_flag_q}, {31'h0, pd});
			check({28'h0, ext_addr_q, load_ctrl_q}, {28'h0, ch, ~ch});
			check({30'h0, pdmode_q}, {30'h0, w[13:12]});
			check({31'h0, busy_q}, 32'h0);
			wr(4'h4, 32'h2);
			rdreg(4'h4, rd);
			check(rd, 32'h0);
		end
		run(2'h1, 2'h0, 1'h0);
		rdreg(4'h4, rd);
		check(rd, 32'h6);
		check({31'h0, busy_q}, 32'h0);
		rdreg(4'hC, rd);
		check(rd, 32'h0);
		results;
	end
endmodule

// >>> two_wire_if.sv
// Open-drain two-wire link joining the controller and the converter end
interface two_wire_if;
	logic mscl_o;
	logic mscl_oe;
	logic msda_o;
	logic msda_oe;
	logic dsda_o;
	logic dsda_oe;
	logic scl;
	logic sda;

	// Pulled high unless an enabled driver pulls low
	assign scl = !(mscl_oe && !mscl_o);
	assign sda = !((msda_oe && !msda_o) || (dsda_oe && !dsda_o));

	modport master (
		output mscl_o,
		output mscl_oe,
		output msda_o,
		output msda_oe,
		input scl,
		input sda
	);

	modport device (
		output dsda_o,
		output dsda_oe,
		input scl,
		input sda
	);
endinterface
